// ==== rcb_pkg.sv ====
// shared constants and types for the rtc calendar register block
package rcb_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_TIME = 8'h00;
  localparam logic [7:0] OFS_DATE = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PRESC = 8'h10;
  localparam logic [7:0] OFS_ALARM0 = 8'h1c;
  localparam logic [7:0] OFS_KEY = 8'h24;
  localparam logic [7:0] OFS_SUBSEC = 8'h28;
  localparam logic [7:0] OFS_SHIFT = 8'h2c;
  localparam logic [7:0] OFS_TS_TIME = 8'h30;
  localparam logic [7:0] OFS_TS_DATE = 8'h34;

  // control fields
  localparam int CTL_TS_EDGE = 3;
  localparam int CTL_REF_DET = 4;
  localparam int CTL_BYPASS = 5;
  localparam int CTL_HOUR12 = 6;
  localparam int CTL_ALARM0_EN = 8;
  localparam int CTL_TS_EN = 11;
  localparam logic [31:0] CTL_WMASK = 32'h00ff_9978;

  // status fields
  localparam int ST_TAMPER1 = 14;
  localparam int ST_TAMPER0 = 13;
  localparam int ST_TS_OVR = 12;
  localparam int ST_TS = 11;
  localparam int ST_ALARM0 = 8;
  localparam int ST_INIT_REQ = 7;
  localparam int ST_SYNCED = 5;
  localparam logic [1:0] ST_RSVD_2_1 = 2'h3;

  // reset values and masks
  localparam logic [31:0] PRESC_RST = 32'h007f_00ff;
  localparam logic [31:0] PRESC_MASK = 32'h007f_7fff;
  localparam logic [31:0] ALARM0_MASK = 32'hffff_ffff;
  localparam logic [31:0] TS_TIME_MASK = 32'h007f_7f7f;
  localparam logic [31:0] TS_DATE_MASK = 32'h0000_ff3f;
  localparam logic [31:0] DATE_SHADOW_RST = 32'h0000_2101;
  localparam logic [14:0] REF_DET_FACTOR_S = 15'h00ff;
  localparam int PRESC_A_LSB = 16;
  localparam int PRESC_A_W = 7;
  localparam int PRESC_S_W = 15;
  localparam int SHIFT_ADD1 = 31;

  // unlock sequence, values arbitrary
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'h5a;

  // source ticks between shadow refreshes, minus one
  localparam logic [0:0] SYNC_PERIOD_M1 = 1'h1;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
  } rcb_ahb_req_t;

  typedef struct packed {
    logic [31:0] time_v;
    logic [31:0] date_v;
  } rcb_cal_t;

endpackage

// ==== rcb_rtc_regs.sv ====
// rtc calendar register block with ahb-lite slave, prescalers and event flags
`timescale 1ns/1ps
module rcb_rtc_regs (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic bkp_rst_n,
  input wire rcb_pkg::rcb_ahb_req_t ahb_req,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rtcclk_pin,
  input wire logic timestamp_pin,
  input wire logic [1:0] tamper_pin,
  input wire rcb_pkg::rcb_cal_t cal_live,
  output logic async_divided_tick,
  output logic sync_divided_tick,
  output logic cal_run,
  output logic hour_format_12,
  output logic ref_clock_detect_en,
  output logic alarm0_flag
);
  import rcb_pkg::*;

  typedef struct packed {
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic key_stage;
    logic unlocked;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [2:0] pin_vld;
    logic init_mode_request;
    logic init_state_flag;
    logic shadow_synced_flag;
    logic sync_phase;
    logic [31:0] shadow_time;
    logic [31:0] shadow_date;
    logic apre_pulse;
    logic spre_pulse;
  } rcb_sys_t;

  typedef struct packed {
    logic [31:0] control;
    logic [31:0] presc;
    logic [31:0] alarm0;
    logic [PRESC_A_W-1:0] apre_cnt;
    logic [15:0] sub_cnt;
    logic [PRESC_S_W-1:0] subtract_fraction;
    logic add_one_second;
    logic shift_pending_flag;
    logic tamper1_flag;
    logic tamper0_flag;
    logic timestamp_overflow_flag;
    logic timestamp_flag;
    logic alarm0_flag;
    logic [31:0] ts_time;
    logic [31:0] ts_date;
    logic match_prev;
  } rcb_bkp_t;

  rcb_sys_t s_q;
  rcb_sys_t s_d;
  rcb_bkp_t b_q;
  rcb_bkp_t b_d;

  logic ap_take;
  logic wr_en;
  logic [31:0] wd;
  logic wr_control;
  logic wr_status;
  logic wr_presc;
  logic wr_alarm0;
  logic wr_key;
  logic wr_shift;
  logic shift_ok;
  logic pins_ok;
  logic src_tick;
  logic ts_rise;
  logic ts_fall;
  logic ts_evt;
  logic [1:0] tamper_evt;
  logic clr_ts;
  logic [PRESC_A_W-1:0] factor_a;
  logic [PRESC_S_W-1:0] factor_s;
  logic apre_now;
  logic spre_now;
  logic alarm0_write_allowed;
  logic alarm_match;
  logic day_ok;
  logic year_configured_flag;
  logic [31:0] status_view;
  logic [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

  assign ap_take = ahb_req.hsel && ahb_req.htrans[1] && hready;
  assign wr_en = s_q.dp_wr;
  assign wd = ahb_req.hwdata;
  assign wr_control = wr_en && (s_q.dp_addr == OFS_CONTROL);
  assign wr_status = wr_en && (s_q.dp_addr == OFS_STATUS);
  assign wr_presc = wr_en && (s_q.dp_addr == OFS_PRESC);
  assign wr_alarm0 = wr_en && (s_q.dp_addr == OFS_ALARM0);
  assign wr_key = wr_en && (s_q.dp_addr == OFS_KEY);
  assign wr_shift = wr_en && (s_q.dp_addr == OFS_SHIFT);
  assign shift_ok = wr_shift && s_q.unlocked && !b_q.shift_pending_flag;

  // edges are taken from the second and third stages only, and only once
  // all stages hold real pin samples, so a high pin gives no edge after reset
  assign pins_ok = s_q.pin_vld[2];
  assign src_tick = pins_ok && s_q.pin_s2[0] && !s_q.pin_s3[0];
  assign ts_rise = pins_ok && s_q.pin_s2[1] && !s_q.pin_s3[1];
  assign ts_fall = pins_ok && !s_q.pin_s2[1] && s_q.pin_s3[1];
  assign ts_evt = b_q.control[CTL_TS_EN] &&
    (b_q.control[CTL_TS_EDGE] ? ts_fall : ts_rise);
  assign tamper_evt = {2{pins_ok}} & s_q.pin_s2[3:2] & ~s_q.pin_s3[3:2];
  assign clr_ts = wr_status && !wd[ST_TS];

  assign factor_a = b_q.presc[PRESC_A_LSB +: PRESC_A_W];
  assign factor_s = b_q.presc[PRESC_S_W-1:0];
  assign apre_now = src_tick && !s_q.init_state_flag && (b_q.apre_cnt == '0);
  assign spre_now = apre_now && !b_q.shift_pending_flag && (b_q.sub_cnt == '0);

  assign alarm0_write_allowed = !b_q.control[CTL_ALARM0_EN] || s_q.init_state_flag;
  assign year_configured_flag = (cal_live.date_v[23:16] != 8'h00);

  // weekday compare ignores the day tens field
  assign day_ok = b_q.alarm0[30] ?
    (b_q.alarm0[27:24] == {1'b0, cal_live.date_v[15:13]}) :
    (b_q.alarm0[29:24] == cal_live.date_v[5:0]);
  assign alarm_match = (b_q.alarm0[31] || day_ok) &&
    (b_q.alarm0[23] || (b_q.alarm0[22:16] == cal_live.time_v[22:16])) &&
    (b_q.alarm0[15] || (b_q.alarm0[14:8] == cal_live.time_v[14:8])) &&
    (b_q.alarm0[7] || (b_q.alarm0[6:0] == cal_live.time_v[6:0]));

  assign status_view = {15'h0000, 1'b0, 1'b0, b_q.tamper1_flag, b_q.tamper0_flag,
    b_q.timestamp_overflow_flag, b_q.timestamp_flag, 2'h0, b_q.alarm0_flag,
    s_q.init_mode_request, s_q.init_state_flag, s_q.shadow_synced_flag,
    year_configured_flag, b_q.shift_pending_flag, ST_RSVD_2_1, alarm0_write_allowed};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ahb_req.haddr[7:0])
      OFS_TIME: rd_mux = b_q.control[CTL_BYPASS] ? cal_live.time_v : s_q.shadow_time;
      OFS_DATE: rd_mux = b_q.control[CTL_BYPASS] ? cal_live.date_v : s_q.shadow_date;
      OFS_CONTROL: rd_mux = b_q.control;
      OFS_STATUS: rd_mux = status_view;
      OFS_PRESC: rd_mux = b_q.presc;
      OFS_ALARM0: rd_mux = b_q.alarm0;
      OFS_SUBSEC: rd_mux = {16'h0000, b_q.sub_cnt};
      OFS_TS_TIME: rd_mux = b_q.ts_time;
      OFS_TS_DATE: rd_mux = b_q.ts_date;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    b_d = b_q;

    // bus front end: address phase captured, read data registered
    s_d.dp_wr = ap_take && ahb_req.hwrite;
    s_d.dp_addr = ahb_req.haddr[7:0];
    if (ap_take && !ahb_req.hwrite) begin
      s_d.rdata = rd_mux;
    end

    s_d.pin_s1 = {tamper_pin, timestamp_pin, rtcclk_pin};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    s_d.pin_vld = {s_q.pin_vld[1:0], 1'b1};

    // key sequence; any other value relocks
    if (wr_key) begin
      if (wd[7:0] == KEY_FIRST) begin
        s_d.key_stage = 1'b1;
        s_d.unlocked = 1'b0;
      end else if (s_q.key_stage && wd[7:0] == KEY_SECOND) begin
        s_d.key_stage = 1'b0;
        s_d.unlocked = 1'b1;
      end else begin
        s_d.key_stage = 1'b0;
        s_d.unlocked = 1'b0;
      end
    end

    if (wr_control && s_q.unlocked) begin
      b_d.control = (b_q.control & ~CTL_WMASK) | (wd & CTL_WMASK);
      if (!s_q.init_state_flag) begin
        b_d.control[CTL_HOUR12] = b_q.control[CTL_HOUR12];
      end
      if (!s_q.init_state_flag || factor_s != REF_DET_FACTOR_S) begin
        b_d.control[CTL_REF_DET] = b_q.control[CTL_REF_DET];
      end
    end

    if (wr_presc && s_q.unlocked && s_q.init_state_flag) begin
      b_d.presc = wd & PRESC_MASK;
    end
    if (wr_alarm0 && s_q.unlocked && s_q.init_state_flag) begin
      b_d.alarm0 = wd & ALARM0_MASK;
    end

    // init handshake: state flag follows request one cycle later
    if (wr_status && s_q.unlocked) begin
      s_d.init_mode_request = wd[ST_INIT_REQ];
    end
    s_d.init_state_flag = s_q.init_mode_request;

    // flag clears first, hardware sets below win
    if (wr_status) begin
      if (!wd[ST_TAMPER1]) b_d.tamper1_flag = 1'b0;
      if (!wd[ST_TAMPER0]) b_d.tamper0_flag = 1'b0;
      if (!wd[ST_TS_OVR]) b_d.timestamp_overflow_flag = 1'b0;
      if (!wd[ST_ALARM0]) b_d.alarm0_flag = 1'b0;
      if (!wd[ST_SYNCED] && s_q.unlocked) s_d.shadow_synced_flag = 1'b0;
    end
    if (clr_ts) begin
      b_d.timestamp_flag = 1'b0;
      b_d.ts_time = 32'h0000_0000;
      b_d.ts_date = 32'h0000_0000;
    end

    if (tamper_evt[1]) b_d.tamper1_flag = 1'b1;
    if (tamper_evt[0]) b_d.tamper0_flag = 1'b1;

    if (ts_evt) begin
      if (b_q.timestamp_flag && !clr_ts) begin
        b_d.timestamp_overflow_flag = 1'b1;
      end else begin
        b_d.timestamp_flag = 1'b1;
        b_d.ts_time = cal_live.time_v & TS_TIME_MASK;
        b_d.ts_date = cal_live.date_v & TS_DATE_MASK;
      end
    end

    b_d.match_prev = alarm_match;
    if (alarm_match && !b_q.match_prev && b_q.control[CTL_ALARM0_EN]) begin
      b_d.alarm0_flag = 1'b1;
    end

    if (shift_ok) begin
      b_d.subtract_fraction = wd[PRESC_S_W-1:0];
      b_d.add_one_second = wd[SHIFT_ADD1];
      b_d.shift_pending_flag = 1'b1;
      s_d.shadow_synced_flag = 1'b0;
    end

    // prescaler chain; held at its factors while in init
    s_d.apre_pulse = apre_now;
    s_d.spre_pulse = spre_now;
    if (s_q.init_state_flag) begin
      b_d.apre_cnt = factor_a;
      b_d.sub_cnt = {1'b0, factor_s};
    end else if (src_tick) begin
      b_d.apre_cnt = (b_q.apre_cnt == '0) ? factor_a : b_q.apre_cnt - 1'b1;
    end
    if (apre_now) begin
      if (b_q.shift_pending_flag) begin
        b_d.sub_cnt = b_q.sub_cnt + {1'b0, b_q.subtract_fraction};
        b_d.shift_pending_flag = 1'b0;
        s_d.spre_pulse = b_q.add_one_second;
      end else if (b_q.sub_cnt == '0) begin
        b_d.sub_cnt = {1'b0, factor_s};
      end else begin
        b_d.sub_cnt = b_q.sub_cnt - 1'b1;
      end
    end

    // shadow refresh every second source tick; too slow a bus clock
    // misses ticks, so software must bypass then
    if (src_tick) begin
      s_d.sync_phase = s_q.sync_phase ^ 1'b1;
      if (s_q.sync_phase == SYNC_PERIOD_M1 && !s_q.init_mode_request &&
          !b_q.shift_pending_flag && !b_q.control[CTL_BYPASS]) begin
        s_d.shadow_time = cal_live.time_v;
        s_d.shadow_date = cal_live.date_v;
        s_d.shadow_synced_flag = 1'b1;
      end
    end
    if (s_q.init_mode_request || b_q.control[CTL_BYPASS]) begin
      s_d.shadow_synced_flag = 1'b0;
    end
  end

  // system domain: bus, init and sync state
  always_ff @(posedge mclk or negedge arst_n or negedge bkp_rst_n) begin
    if (!arst_n || !bkp_rst_n) begin
      s_q <= '0;
      s_q.shadow_date <= DATE_SHADOW_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // backup domain: untouched by system reset
  always_ff @(posedge mclk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      b_q <= '0;
      b_q.presc <= PRESC_RST;
    end else begin
      b_q <= b_d;
    end
  end

  assign async_divided_tick = s_q.apre_pulse;
  assign sync_divided_tick = s_q.spre_pulse;
  assign cal_run = !s_q.init_state_flag;
  assign hour_format_12 = b_q.control[CTL_HOUR12];
  assign ref_clock_detect_en = b_q.control[CTL_REF_DET];
  assign alarm0_flag = b_q.alarm0_flag;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n || !bkp_rst_n);

  chk_hour_fmt_lock: assert property (
    wr_control && !s_q.init_state_flag |=> $stable(hour_format_12))
    else $error("hour format changed outside init");

  chk_bypass_read: assert property (
    ap_take && !ahb_req.hwrite && ahb_req.haddr[7:0] == OFS_TIME && b_q.control[CTL_BYPASS]
    |=> hrdata == $past(cal_live.time_v))
    else $error("bypassed time read did not return live value");

  chk_ref_det_lock: assert property (
    wr_control && (!s_q.init_state_flag || factor_s != REF_DET_FACTOR_S)
    |=> $stable(ref_clock_detect_en))
    else $error("reference detect changed while locked");

  chk_ts_capture: assert property (
    ts_evt && !b_q.timestamp_flag
    |=> b_q.timestamp_flag && b_q.ts_time == ($past(cal_live.time_v) & TS_TIME_MASK))
    else $error("timestamp not captured");

  chk_ts_overflow: assert property (
    ts_evt && b_q.timestamp_flag && !clr_ts |=> b_q.timestamp_overflow_flag)
    else $error("timestamp overflow not flagged");

  chk_ts_clear: assert property (
    clr_ts && !ts_evt |=> !b_q.timestamp_flag && b_q.ts_time == '0 && b_q.ts_date == '0)
    else $error("timestamp clear left data behind");

  chk_presc_lock: assert property (
    wr_presc && !s_q.init_state_flag |=> $stable(b_q.presc))
    else $error("prescaler written outside init");

  chk_shift_take: assert property (
    shift_ok |=> b_q.shift_pending_flag ##1 $stable(b_q.subtract_fraction))
    else $error("shift write not pending");

  chk_status_lock: assert property (
    wr_status && !s_q.unlocked |=> $stable(s_q.init_mode_request))
    else $error("init request changed while locked");

  chk_alarm_set: assert property (
    alarm_match && !b_q.match_prev && b_q.control[CTL_ALARM0_EN] |=> alarm0_flag[*2])
    else $error("alarm flag not set on match");

  chk_sub_reload: assert property (
    spre_now |=> b_q.sub_cnt == {1'b0, $past(factor_s)} && sync_divided_tick)
    else $error("sync divider reload wrong");
endmodule

// ==== rcb_rtc_regs_tb.sv ====
// self-checking testbench for the rtc calendar register block
`timescale 1ns/1ps
module rcb_rtc_regs_tb;
  import rcb_pkg::*;
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } rcb_row_t;
  logic mclk, arst_n, bkp_rst_n, hready, hreadyout, hresp;
  rcb_ahb_req_t ahb_req;
  logic [31:0] hrdata, rd;
  logic rtcclk_pin, timestamp_pin, src_run;
  logic [1:0] tamper_pin;
  rcb_cal_t cal_live;
  logic async_divided_tick, sync_divided_tick, cal_run, hour_format_12;
  logic ref_clock_detect_en, alarm0_flag;
  int fails, cmp_count, src_cnt;
  // reset values, locked writes and an unmapped place
  rcb_row_t rows[11] = '{
    '{1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0007},
    '{1'b0, OFS_PRESC, 32'h0000_0000, 32'h007f_00ff},
    '{1'b0, OFS_ALARM0, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, OFS_SUBSEC, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, OFS_TS_TIME, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, OFS_TS_DATE, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, OFS_CONTROL, 32'h0000_0000, 32'h0000_0000},
    '{1'b0, OFS_DATE, 32'h0000_0000, 32'h0000_2101},
    '{1'b0, 8'h3c, 32'h0000_0000, 32'h0000_0000},
    '{1'b1, OFS_PRESC, 32'h0001_0002, 32'h007f_00ff},
    '{1'b1, OFS_STATUS, 32'h0000_0080, 32'h0000_0007}
  };

  assign hready = hreadyout;

  rcb_rtc_regs DUT (
    .mclk(mclk), .arst_n(arst_n), .bkp_rst_n(bkp_rst_n), .ahb_req(ahb_req),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rtcclk_pin(rtcclk_pin), .timestamp_pin(timestamp_pin), .tamper_pin(tamper_pin),
    .cal_live(cal_live), .async_divided_tick(async_divided_tick),
    .sync_divided_tick(sync_divided_tick), .cal_run(cal_run),
    .hour_format_12(hour_format_12), .ref_clock_detect_en(ref_clock_detect_en),
    .alarm0_flag(alarm0_flag)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // source clock of eight mclk periods, only while src_run is high
  always @(posedge mclk) begin
    if (src_run) begin
      src_cnt <= (src_cnt == 3) ? 0 : src_cnt + 1;
      if (src_cnt == 3) rtcclk_pin <= ~rtcclk_pin;
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single word transfer; read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge mclk);
    ahb_req.hsel <= 1'b1;
    ahb_req.htrans <= 2'h2;
    ahb_req.hwrite <= wr;
    ahb_req.hsize <= 3'h2;
    ahb_req.haddr <= {24'h00_0000, addr};
    do @(posedge mclk); while (hready !== 1'b1);
    ahb_req.htrans <= 2'h0;
    ahb_req.hwdata <= data;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    ahb(1'b1, addr, data);
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
    ahb(1'b0, addr, 32'h0000_0000);
    chk($sformatf("reg_%h", addr), rd, exp);
  endtask

  task automatic stat;
    ahb(1'b0, OFS_STATUS, 32'h0000_0000);
  endtask

  task automatic gap(input logic sel, input int exp);
    int n;
    int k;
    n = 0;
    k = 0;
    while (k < 2 && n < 500) begin
      @(posedge mclk);
      n++;
      if ((sel ? sync_divided_tick : async_divided_tick) === 1'b1) begin
        k++;
        if (k == 1) n = 0;
      end
    end
    chk(sel ? "sync_gap" : "async_gap", n, exp);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    bkp_rst_n = 1'b0;
    ahb_req = '0;
    rtcclk_pin = 1'b0;
    timestamp_pin = 1'b0;
    tamper_pin = 2'h0;
    src_run = 1'b0;
    src_cnt = 0;
    fails = 0;
    cmp_count = 0;
    cal_live = '{time_v: 32'h0012_3457, date_v: 32'h0000_2315};
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    bkp_rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].data);
      rchk(rows[i].addr, rows[i].exp);
    end
    wr(OFS_KEY, {24'h00_0000, KEY_FIRST});
    wr(OFS_KEY, {24'h00_0000, KEY_SECOND});
    wr(OFS_PRESC, 32'h0001_0002);
    rchk(OFS_PRESC, 32'h007f_00ff);
    chk("hresp", hresp, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0060);
    rchk(OFS_CONTROL, 32'h0000_0020);
    rchk(OFS_DATE, 32'h0000_2315);
    wr(OFS_CONTROL, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_7f80);
    rchk(OFS_STATUS, 32'h0000_00c7);
    chk("cal_run", cal_run, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0850);
    @(negedge mclk);
    chk("ref_det", ref_clock_detect_en, 32'h0000_0001);
    chk("hour12", hour_format_12, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0840);
    wr(OFS_PRESC, 32'h0001_0002);
    rchk(OFS_PRESC, 32'h0001_0002);
    wr(OFS_CONTROL, 32'h0000_0850);
    rchk(OFS_CONTROL, 32'h0000_0840);
    wr(OFS_ALARM0, 32'h8080_8056);
    rchk(OFS_ALARM0, 32'h8080_8056);
    wr(OFS_STATUS, 32'h0000_7f00);
    rchk(OFS_STATUS, 32'h0000_0007);
    chk("cal_run", cal_run, 32'h0000_0001);
    src_run <= 1'b1;
    gap(1'b0, 16);
    gap(1'b1, 48);
    src_run <= 1'b0;
    ahb(1'b0, OFS_SUBSEC, 32'h0000_0000);
    chk("subsec_range", rd <= 32'h0000_0002, 32'h0000_0001);
    wr(OFS_SHIFT, 32'h0000_0001);
    stat();
    chk("shift_pending", rd[3], 32'h0000_0001);
    chk("synced", rd[ST_SYNCED], 32'h0000_0000);
    src_run <= 1'b1;
    repeat (40) @(posedge mclk);
    src_run <= 1'b0;
    stat();
    chk("shift_pending", rd[3], 32'h0000_0000);
    timestamp_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    stat();
    chk("ts_flag", rd[ST_TS], 32'h0000_0001);
    rchk(OFS_TS_TIME, 32'h0012_3457 & TS_TIME_MASK);
    rchk(OFS_TS_DATE, 32'h0000_2315 & TS_DATE_MASK);
    timestamp_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    timestamp_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    stat();
    chk("ts_ovr", rd[ST_TS_OVR], 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_6700);
    stat();
    chk("ts_clear", rd[12:11], 32'h0000_0000);
    rchk(OFS_TS_TIME, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0848);
    timestamp_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    stat();
    chk("ts_fall", rd[ST_TS], 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_6700);
    timestamp_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    stat();
    chk("ts_rise_ignored", rd[ST_TS], 32'h0000_0000);
    tamper_pin <= 2'h2;
    repeat (6) @(posedge mclk);
    stat();
    chk("tamper", rd[14:13], 32'h0000_0002);
    tamper_pin <= 2'h3;
    repeat (6) @(posedge mclk);
    wr(OFS_STATUS, 32'h0000_5f00);
    stat();
    chk("tamper_clr", rd[14:13], 32'h0000_0002);
    wr(OFS_CONTROL, 32'h0000_0948);
    src_run <= 1'b1;
    repeat (40) @(posedge mclk);
    chk("alarm_miss", alarm0_flag, 32'h0000_0000);
    cal_live.time_v <= 32'h0012_3456;
    repeat (40) @(posedge mclk);
    chk("alarm_hit", alarm0_flag, 32'h0000_0001);
    src_run <= 1'b0;
    stat();
    chk("alarm_wr_ok", rd[0], 32'h0000_0000);
    // weekday alarm: day tens ignored, weekday 2 against weekday 1 then 2
    wr(OFS_STATUS, 32'h0000_7e80);
    wr(OFS_ALARM0, 32'h7280_8080);
    wr(OFS_STATUS, 32'h0000_7e00);
    rchk(OFS_ALARM0, 32'h7280_8080);
    chk("weekday_miss", alarm0_flag, 32'h0000_0000);
    cal_live.date_v <= 32'h0000_4315;
    repeat (4) @(posedge mclk);
    chk("weekday_hit", alarm0_flag, 32'h0000_0001);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rchk(OFS_STATUS, 32'h0000_4106);
    rchk(OFS_PRESC, 32'h0001_0002);
    wr(OFS_STATUS, 32'h0000_7f80);
    rchk(OFS_STATUS, 32'h0000_4106);
    stop_test();
  end
endmodule
